// ---- hdl/ffp_predictor.sv ----
// Friction failure predictor: thresholds, auto derivation and warning
`timescale 1ns/1ps
module ffp_predictor #(
  parameter int CYC_PER_SEC = ffp_pkg::CYCLES_PER_SEC,
  parameter int CONT_SEC    = ffp_pkg::CONT_RUN_SEC,
  parameter int CUM_SEC     = ffp_pkg::CUM_RUN_SEC
) (
  // Clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       reset_in,
  // Settings kept across power cycles, caught after reset release
  input  wire ffp_pkg::ffp_cfg_s          boot_cfg_in,
  // Software settings write
  input  wire logic                       cfg_write_in,
  input  wire ffp_pkg::ffp_cfg_s          cfg_in,
  // Friction estimator and machine state
  input  wire logic                       est_valid_in,
  input  wire logic signed [15:0]         est_friction_in,
  input  wire logic                       est_dir_done_in,
  input  wire logic                       run_pos_vel_in,
  input  wire logic [31:0]                travel_distance_in,
  // Results
  output logic                            friction_prediction_warning_out,
  output ffp_pkg::ffp_status_e            status_out,
  output ffp_pkg::ffp_cfg_s               cfg_out,
  output logic signed [21:0]              upper_threshold_out,
  output logic signed [21:0]              lower_threshold_out,
  output logic                            calc_done_out
);
  import ffp_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (CYC_PER_SEC < 1 || CYC_PER_SEC > 33_554_431) $error("CYC_PER_SEC out of range");
  if (CONT_SEC < 1 || CONT_SEC > 1_048_575) $error("CONT_SEC out of range");
  if (CUM_SEC < 1 || CUM_SEC > 1_048_575) $error("CUM_SEC out of range");

  localparam logic [24:0] SEC_LAST  = 25'(CYC_PER_SEC - 1);
  localparam logic [19:0] CONT_LIM  = 20'(CONT_SEC);
  localparam logic [19:0] CUM_LIM   = 20'(CUM_SEC);

  // Threshold from average, deviation and multiplier
  function automatic logic signed [21:0] band_edge(input logic signed [15:0] avg,
                                                   input logic [15:0] dev,
                                                   input logic [3:0] mult,
                                                   input logic upper);
    logic        [3:0]  m;
    logic signed [21:0] span;
    m    = (mult == 4'h0) ? DEFAULT_MULT : mult;
    span = $signed({2'b00, 20'(dev) * 20'(m)}); // Full 20-bit product, no wrap
    band_edge = upper ? 22'(avg + span) : 22'(avg - span);
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  ffp_cfg_s           cfg;
  logic               boot_pending;
  logic               warn;
  logic               calc_done;
  logic               have_sample;
  logic signed [15:0] ema_mean;
  logic        [15:0] ema_dev;
  logic        [24:0] sec_div;
  logic        [19:0] cont_sec;
  logic        [19:0] cum_sec;
  logic signed [21:0] upper_thr;
  logic signed [21:0] lower_thr;

  // ************************************************************
  // Decode
  // ************************************************************
  wire logic               half_passed = travel_distance_in > {1'b0, cfg.life_travel_distance[31:1]};
  wire logic               mode_auto   = cfg.prediction_mode_select == MODE_AUTO;
  wire logic               mode_manual = cfg.prediction_mode_select == MODE_MANUAL;
  wire logic               active      = mode_manual && half_passed;
  wire logic               sec_tick    = run_pos_vel_in && (sec_div == SEC_LAST);
  wire logic               collecting  = mode_auto && half_passed && run_pos_vel_in;
  wire logic               derive_now  = mode_auto && half_passed && have_sample && est_dir_done_in
                                         && (cont_sec >= CONT_LIM) && (cum_sec >= CUM_LIM);
  wire logic signed [21:0] est_wide    = 22'(est_friction_in);
  wire logic               outside     = (est_wide > upper_thr) || (est_wide < lower_thr);
  wire logic signed [16:0] diff        = 17'(est_friction_in) - 17'(ema_mean);
  wire logic        [15:0] abs_diff    = diff[16] ? 16'(-diff) : diff[15:0];
  wire logic signed [15:0] next_mean   = 16'(ema_mean + 16'(diff >>> EMA_SHIFT));
  wire logic signed [16:0] dev_step    = 17'({1'b0, abs_diff}) - 17'({1'b0, ema_dev});
  wire logic        [15:0] next_dev    = 16'($signed(17'({1'b0, ema_dev})) + (dev_step >>> EMA_SHIFT));

  // Settings: boot load, software write, and own rewrites in auto mode
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cfg <= '{MODE_OFF, 4'h0, RST_LIFE, RST_AVG, RST_DEV};
    end else if (boot_pending) begin
      cfg <= boot_cfg_in;
      if (boot_cfg_in.prediction_mode_select == MODE_RESET) begin
        cfg.prediction_mode_select <= MODE_AUTO;
        cfg.friction_average_value <= RST_AVG;
        cfg.friction_std_deviation <= RST_DEV;
      end
    end else if (derive_now) begin
      cfg.friction_average_value <= ema_mean;
      cfg.friction_std_deviation <= ema_dev;
      cfg.prediction_mode_select <= MODE_MANUAL;
    end else if (cfg_write_in) begin
      cfg <= cfg_in; // Code 3 only stored; it acts at the next power-up
    end
  end

  // Boot catch happens one cycle after release, never under reset
  always_ff @(posedge mclk_in) begin
    if (reset_in) boot_pending <= 1'b1;
    else          boot_pending <= 1'b0;
  end

  // Run time counters; continuous time restarts whenever running stops
  always_ff @(posedge mclk_in) begin
    if (reset_in || !run_pos_vel_in) begin
      sec_div  <= 25'h0000000;
      cont_sec <= 20'h00000;
    end else begin
      sec_div <= sec_tick ? 25'h0000000 : 25'(sec_div + 25'h0000001);
      if (sec_tick && cont_sec != 20'hFFFFF) cont_sec <= 20'(cont_sec + 20'h00001);
    end
  end

  // Cumulative time only counts after half the life distance
  always_ff @(posedge mclk_in) begin
    if (reset_in || !mode_auto) cum_sec <= 20'h00000;
    else if (sec_tick && half_passed && cum_sec != 20'hFFFFF) cum_sec <= 20'(cum_sec + 20'h00001);
  end

  // Running mean and mean absolute deviation of the estimates
  always_ff @(posedge mclk_in) begin
    if (reset_in || !mode_auto) begin
      have_sample <= 1'b0;
      ema_mean    <= 16'sh0000;
      ema_dev     <= 16'h0000;
    end else if (est_valid_in && collecting) begin
      have_sample <= 1'b1;
      ema_mean    <= have_sample ? next_mean : est_friction_in;
      ema_dev     <= have_sample ? next_dev : 16'h0000;
    end
  end

  // Calculation-done flag, dropped when auto mode is re-entered
  always_ff @(posedge mclk_in) begin
    if (reset_in)       calc_done <= 1'b0;
    else if (mode_auto) calc_done <= derive_now;
  end

  // Thresholds, registered so the compare sees settled edges
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      upper_thr <= 22'sh000000;
      lower_thr <= 22'sh000000;
    end else begin
      upper_thr <= band_edge(cfg.friction_average_value, cfg.friction_std_deviation,
                             cfg.threshold_multiplier, 1'b1);
      lower_thr <= band_edge(cfg.friction_average_value, cfg.friction_std_deviation,
                             cfg.threshold_multiplier, 1'b0);
    end
  end

  // Warning level, judged again on each new estimate
  always_ff @(posedge mclk_in) begin
    if (reset_in || !active) warn <= 1'b0;
    else if (est_valid_in)   warn <= outside;
  end

  // Outputs
  assign friction_prediction_warning_out = warn;
  assign cfg_out             = cfg;
  assign upper_threshold_out = upper_thr;
  assign lower_threshold_out = lower_thr;
  assign calc_done_out       = calc_done;
  assign status_out = (mode_auto || mode_manual) ?
                      (warn ? ST_WARNING : (active ? ST_EXECUTING : ST_PREPARING)) :
                      ST_DISABLED;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  property p_warn_set;
    est_valid_in && active && outside ##1 active |-> warn;
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning not raised");

  property p_warn_clear;
    est_valid_in && !outside && warn |=> !warn;
  endproperty
  a_warn_clear: assert property (p_warn_clear) else $error("warning not cleared");

  property p_warn_hold;
    warn && !est_valid_in && active |=> warn;
  endproperty
  a_warn_hold: assert property (p_warn_hold) else $error("warning dropped early");

  property p_no_warn_auto;
    mode_auto && $past(mode_auto) |-> !warn; // Level from manual drains one cycle after switch
  endproperty
  a_no_warn_auto: assert property (p_no_warn_auto) else $error("warning in auto mode");

  property p_manual_gate;
    !half_passed |=> !warn;
  endproperty
  a_manual_gate: assert property (p_manual_gate) else $error("warning before half life");

  property p_auto_to_manual;
    derive_now && !boot_pending |=> cfg.prediction_mode_select == MODE_MANUAL && calc_done;
  endproperty
  a_auto_to_manual: assert property (p_auto_to_manual) else $error("mode not switched");

  property p_derive_values;
    derive_now && !boot_pending |=> cfg.friction_average_value == $past(ema_mean)
                                    && cfg.friction_std_deviation == $past(ema_dev);
  endproperty
  a_derive_values: assert property (p_derive_values) else $error("averages not written");

  property p_derive_gate;
    calc_done && !$past(calc_done) |-> $past(cont_sec) >= CONT_LIM && $past(cum_sec) >= CUM_LIM
                                       && $past(est_dir_done_in) && $past(half_passed);
  endproperty
  a_derive_gate: assert property (p_derive_gate) else $error("derived too early");

  property p_boot_reset;
    boot_pending && boot_cfg_in.prediction_mode_select == MODE_RESET |=>
      cfg.prediction_mode_select == MODE_AUTO && cfg.friction_std_deviation == RST_DEV;
  endproperty
  a_boot_reset: assert property (p_boot_reset) else $error("threshold reset missed");

  property p_mult_zero;
    cfg.threshold_multiplier == 4'h0 ##1 cfg.threshold_multiplier == 4'h0 |->
      upper_thr == 22'($past(cfg.friction_average_value))
                   + 22'($past(cfg.friction_std_deviation) * 5);
  endproperty
  a_mult_zero: assert property (p_mult_zero) else $error("default multiplier wrong");

  property p_status;
    warn |-> status_out == ST_WARNING;
  endproperty
  a_status: assert property (p_status) else $error("status not warning");

  c_warn_raise:  cover property (!warn ##1 warn);
  c_warn_cancel: cover property (warn ##1 !warn);
  c_derive:      cover property (derive_now);
  c_boot_reset:  cover property (boot_pending && boot_cfg_in.prediction_mode_select == MODE_RESET);

endmodule

// ---- hdl/ffp_pkg.sv ----
// Constants, modes and carrier types of the friction failure predictor
// Summary of operation
// - Mode 0 off, 1 auto, 2 manual, 3 reset
// - Upper avg plus dev*mult, lower avg minus
// - Multiplier zero is taken as five
// - Active prediction warns when friction leaves band
// - Warning clears once friction back inside band
// - Auto mode turns manual after thresholds done
// - Reset code at power-up clears thresholds, auto
// - Auto completes after half distance, 3h, 90h
// - Auto mode no warning before calculation done
// - Manual prediction starts after half life distance
// - Auto overwrites average and deviation from estimates
// - No derivation without 3h run, direction estimate
// - Prediction compares once thresholds are supplied
// - Status 0 off, 1 preparing, 2 executing, 3 warning
package ffp_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ         = 25_000_000;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int SEC_PER_HOUR   = 3600;
  localparam int CONT_RUN_HOURS = 3;
  localparam int CUM_RUN_HOURS  = 90;
  localparam int CYCLES_PER_SEC = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int CONT_RUN_SEC   = CONT_RUN_HOURS * SEC_PER_HOUR;
  localparam int CUM_RUN_SEC    = CUM_RUN_HOURS * SEC_PER_HOUR;

  // ************************************************************
  // Field widths and values
  // ************************************************************
  localparam int             FRIC_W       = 16;
  localparam int             THR_W        = 22;
  localparam int             MULT_W       = 4;
  localparam int             DIST_W       = 32;
  localparam logic [3:0]     DEFAULT_MULT = 4'h5;
  localparam int             EMA_SHIFT    = 4;
  localparam logic [15:0]    RST_AVG      = 16'h0000;
  localparam logic [15:0]    RST_DEV      = 16'h0000;
  localparam logic [31:0]    RST_LIFE     = 32'h0000_0000;

  // Selection codes
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_AUTO   = 2'h1,
    MODE_MANUAL = 2'h2,
    MODE_RESET  = 2'h3
  } ffp_mode_e;

  // Reported prediction status
  typedef enum logic [3:0] {
    ST_DISABLED  = 4'h0,
    ST_PREPARING = 4'h1,
    ST_EXECUTING = 4'h2,
    ST_WARNING   = 4'h3
  } ffp_status_e;

  // Settings set, as written by software or kept across power cycles
  typedef struct packed {
    ffp_mode_e          prediction_mode_select;
    logic [3:0]         threshold_multiplier;
    logic [31:0]        life_travel_distance;
    logic signed [15:0] friction_average_value;
    logic [15:0]        friction_std_deviation;
  } ffp_cfg_s;

endpackage

// ---- tb/ffp_est_model.sv ----
// Friction estimator stand-in that feeds the predictor
`timescale 1ns/1ps
module ffp_est_model (
  // Clock
  input  wire logic          mclk_in,
  // Estimates toward the predictor
  output logic               est_valid_out,
  output logic signed [15:0] est_friction_out,
  output logic               dir_done_out
);
  // Quiet start: no estimate, direction not finished
  initial begin
    est_valid_out    = 1'b0;
    est_friction_out = 16'h0000;
    dir_done_out     = 1'b0;
  end
  // One estimate, valid for one cycle then dropped; stale data shown inverted so it never looks valid
  task automatic send(input logic signed [15:0] val);
    @(negedge mclk_in);
    est_valid_out    = 1'b1;
    est_friction_out = val;
    @(negedge mclk_in);
    est_valid_out    = 1'b0;
    est_friction_out = ~val;
  endtask
  // Direction estimate finished or not
  task automatic set_done(input logic done);
    @(negedge mclk_in);
    dir_done_out = done;
  endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the friction failure predictor
`timescale 1ns/1ps
module testbench;
  import ffp_pkg::*;
  // ************************************************************
  // Stimulus, results and bookkeeping
  // ************************************************************
  logic               mclk_in   = 1'b0;
  logic               reset_in  = 1'b1;
  logic               cfg_write = 1'b0;
  logic               run       = 1'b0;
  logic [31:0]        travel    = 32'h0;
  ffp_cfg_s           boot_cfg;
  ffp_cfg_s           cfg;
  ffp_cfg_s           cfg_now;
  ffp_status_e        status;
  logic               est_valid;
  logic               dir_done;
  logic               warn;
  logic               calc_done;
  logic signed [15:0] est_val;
  logic signed [21:0] upper;
  logic signed [21:0] lower;
  logic [31:0]        notes[$];
  logic [31:0]        seen;
  event               result_ev;
  int                 miscompares = 0;
  int                 comparisons = 0;
  int                 m;
  int                 a;
  int                 d;

  // 25 MHz clock
  always #20 mclk_in = ~mclk_in;

  // Estimator and the block; short second counts keep derivation brief
  ffp_est_model u_est (.mclk_in(mclk_in), .est_valid_out(est_valid),
    .est_friction_out(est_val), .dir_done_out(dir_done));
  ffp_predictor #(.CYC_PER_SEC(4), .CONT_SEC(3), .CUM_SEC(5)) u_dut (
    .mclk_in(mclk_in), .reset_in(reset_in), .boot_cfg_in(boot_cfg),
    .cfg_write_in(cfg_write), .cfg_in(cfg), .est_valid_in(est_valid),
    .est_friction_in(est_val), .est_dir_done_in(dir_done), .run_pos_vel_in(run),
    .travel_distance_in(travel), .friction_prediction_warning_out(warn),
    .status_out(status), .cfg_out(cfg_now), .upper_threshold_out(upper),
    .lower_threshold_out(lower), .calc_done_out(calc_done));

  // ************************************************************
  // Checking and closing
  // ************************************************************
  // Note the expectation, then hand the observed value to the monitor
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    notes.push_back(exp);
    seen = got;
    -> result_ev;
    #1;
  endtask
  // Monitor: oldest note against each result as it appears
  always @(result_ev) begin
    comparisons++;
    if (seen !== notes[0]) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, seen, notes[0]);
    end
    void'(notes.pop_front());
  end
  // Verdict and end of run
  task automatic conclude();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ************************************************************
  // Drivers
  // ************************************************************
  // Settings write; thresholds settle one cycle after the write edge
  task automatic wr(input ffp_mode_e md, input int mu, input int av, input int dv);
    @(negedge mclk_in);
    cfg_write = 1'b1;
    cfg = '{md, 4'(mu), 32'h64, 16'(av), 16'(dv)};
    @(negedge mclk_in);
    cfg_write = 1'b0;
    repeat (2) @(negedge mclk_in);
  endtask
  // Estimate, then warning and status one cycle after it is taken
  task automatic est(input int v, input logic w, input ffp_status_e s);
    u_est.send(16'(v));
    @(negedge mclk_in);
    check(warn, w);
    check(status, s);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    boot_cfg = '{MODE_RESET, 4'h6, 32'h64, 16'h0123, 16'h0045};
    cfg = '0;
    void'($urandom(32'h913DBBD1));
    repeat (16) @(negedge mclk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    check(cfg_now.prediction_mode_select, MODE_AUTO);
    check(cfg_now.friction_average_value, 16'h0);
    check(upper, 32'h0);
    check(status, ST_PREPARING);
    // Threshold arithmetic over random settings, first with zero multiplier
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 0 : $urandom_range(15, 1);
      a = $urandom_range(2000) - 1000;
      d = $urandom_range(500);
      wr(MODE_MANUAL, m, a, d);
      if (m == 0) m = 5;
      check(upper, a + d * m);
      check(lower, a - d * m);
    end
    // Manual band 50..150; exactly half the life distance is not enough
    wr(MODE_MANUAL, 0, 100, 10);
    travel = 32'h32;
    est(200, 1'b0, ST_PREPARING);
    travel = 32'h33;
    est(150, 1'b0, ST_EXECUTING);
    est(151, 1'b1, ST_WARNING);
    est(120, 1'b0, ST_EXECUTING);
    est(49, 1'b1, ST_WARNING);
    est(49, 1'b1, ST_WARNING);
    est(50, 1'b0, ST_EXECUTING);
    wr(MODE_OFF, 0, 100, 10);
    est(300, 1'b0, ST_DISABLED);
    wr(MODE_RESET, 0, 100, 10);
    check(status, ST_DISABLED);
    // Auto mode: no warning and no derivation while direction unfinished
    wr(MODE_AUTO, 0, 0, 0);
    run = 1'b1;
    for (int i = 0; i < 20; i++) begin
      est(200, 1'b0, ST_PREPARING);
    end
    check(calc_done, 1'b0);
    u_est.set_done(1'b1);
    for (int i = 0; i < 200 && calc_done !== 1'b1; i++) begin
      @(negedge mclk_in);
    end
    check(calc_done, 1'b1);
    if (calc_done === 1'b1) begin
      check(cfg_now.prediction_mode_select, MODE_MANUAL);
      check(cfg_now.friction_average_value, 16'h00C8);
      check(cfg_now.friction_std_deviation, 16'h0);
      @(negedge mclk_in);
      check(upper, 32'hC8);
      est(200, 1'b0, ST_EXECUTING);
      est(201, 1'b1, ST_WARNING);
      // Derived band too tight: reload derived average, widen multiplier
      wr(MODE_MANUAL, 6, 200, 1);
      check(warn, 1'b1);
      check(upper, 32'hCE);
      check(lower, 32'hC2);
      est(201, 1'b0, ST_EXECUTING);
    end
    // Power cycle with a stored manual image: taken as it stands
    boot_cfg = '{MODE_MANUAL, 4'h2, 32'h64, 16'h0064, 16'h000A};
    @(negedge mclk_in);
    reset_in = 1'b1;
    repeat (16) @(negedge mclk_in);
    reset_in = 1'b0;
    check(warn, 1'b0);
    repeat (3) @(negedge mclk_in);
    check(cfg_now.prediction_mode_select, MODE_MANUAL);
    check(upper, 32'h78);
    check(calc_done, 1'b0);
    check(status, ST_EXECUTING);
    conclude();
  end
endmodule
